// file: ijhd_map.svh
`ifndef IJHD_MAP_SVH
`define IJHD_MAP_SVH

// ****************************************************************
// widths
// ****************************************************************
`define IJHD_NOZZLES 16
`define IJHD_CW_BITS 10
`define IJHD_ROWS 13
`define IJHD_CODE_BITS 4
`define IJHD_ADC_BITS 8
`define IJHD_ADR_BITS 8
`define IJHD_DAT_BITS 32

// ****************************************************************
// scanning counter
// ****************************************************************
`define IJHD_STEP_ZERO 4'h0
`define IJHD_STEP_LAST 4'hd
`define IJHD_STEP_ONE 4'h1

// ****************************************************************
// control word fields
// ****************************************************************
`define IJHD_CW_ON_BIT 0
`define IJHD_CW_HEADB_BIT 1

// ****************************************************************
// register offsets (byte addresses) and result reset value
// ****************************************************************
`define IJHD_ADR_RESULT 8'h00
`define IJHD_ADR_STATUS 8'h04
`define IJHD_ADR_LATCH 8'h08
`define IJHD_RESULT_RST 8'h00

`endif

// file: ijhd_pkg.sv
`include "ijhd_map.svh"

package ijhd_pkg;

    // all pins that arrive from outside the clock domain
    typedef struct packed {
        logic ctrl_word_latch_strobe;
        logic ctrl_serial_clock;
        logic ctrl_serial_in;
        logic nozzle_latch_clear;
        logic nozzle_check_mode;
        logic nozzle_latch_strobe;
        logic nozzle_serial_in;
        logic nozzle_serial_clock;
        logic long_fire_strobe;
        logic short_fire_strobe;
        logic conversion_start;
        logic converter_clock;
        logic scan_counter_enable;
        logic head_channel_select;
        logic row_code_bit3;
        logic count_direction_or_code_bit2;
        logic count_reset_or_code_bit1;
        logic count_clock_or_code_bit0;
        logic row_outputs_enable_n;
        logic temp_source_enable_n;
        logic open_load_detect;
        logic row_short_detect;
    } ijhd_pins_type;

    // whole state of the driver
    typedef struct packed {
        ijhd_pins_type sy1;
        ijhd_pins_type sy2;
        ijhd_pins_type prev;
        logic [`IJHD_NOZZLES-1:0] nshift;
        logic [`IJHD_NOZZLES-1:0] nlatch;
        logic [`IJHD_CW_BITS-1:0] cshift;
        logic [`IJHD_CW_BITS-1:0] cword;
        logic [`IJHD_CODE_BITS-1:0] step;
        logic [`IJHD_NOZZLES-1:0] col;
        logic [`IJHD_NOZZLES-1:0] tsrc;
        logic [`IJHD_ROWS-1:0] rows_a;
        logic [`IJHD_ROWS-1:0] rows_b;
        logic temp_a;
        logic temp_b;
        logic fault;
        logic [`IJHD_ADC_BITS-1:0] result;
        logic [`IJHD_ADC_BITS-1:0] adc_sh;
        logic adc_out;
        logic ack;
        logic [`IJHD_DAT_BITS-1:0] rdata;
    } ijhd_state_type;

endpackage

// file: ijhd_top.sv
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ns
`include "ijhd_map.svh"

// Contract
// - word loads from shift register while latch strobe high
// - column on only with check low and a strobe low
// - latch-clear high zeroes nozzle latch
// - check mode: columns off, source on if bit set, long low
// - latch strobe rise copies 16 shift bits
// - nozzle clock rise shifts data in
// - long strobe low fires set columns
// - short strobe low fires clear columns
// - reset low clears all state except the sync and edge-detect stages, which load the pin idle levels
// - conversion start high lets conversion run
// - result out on converter clock, read on its fall
// - fault: open load in check mode, else row short
// - counter enabled: decoder follows counter
// - select low routes rows to head A, high to B
// - counter disabled: decoder takes code pins
// - direction high counts up, low down
// - counter reset low zeroes counter
// - rows driven only while row enable low
// - counter steps once per clock pulse
// - temp source on with enable low, steered by word
// - control clock rise shifts data in
// - control shift register and word hold ten bits
// - codes map to rows 1 to 13, three codes idle
module ijhd_top (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // serial control word port
    input wire logic ctrl_word_latch_strobe_i,
    input wire logic ctrl_serial_clock_i,
    input wire logic ctrl_serial_in_i,
    // nozzle data port
    input wire logic nozzle_latch_clear_i,
    input wire logic nozzle_check_mode_i,
    input wire logic nozzle_latch_strobe_i,
    input wire logic nozzle_serial_in_i,
    input wire logic nozzle_serial_clock_i,
    input wire logic long_fire_strobe_i,
    input wire logic short_fire_strobe_i,
    // converter port
    input wire logic conversion_start_i,
    input wire logic converter_clock_i,
    // head address selector
    input wire logic scan_counter_enable_i,
    input wire logic head_channel_select_i,
    input wire logic row_code_bit3_i,
    input wire logic count_direction_or_code_bit2_i,
    input wire logic count_reset_or_code_bit1_i,
    input wire logic count_clock_or_code_bit0_i,
    input wire logic row_outputs_enable_n_i,
    // temperature source and sense inputs
    input wire logic temp_source_enable_n_i,
    input wire logic open_load_detect_i,
    input wire logic row_short_detect_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`IJHD_ADR_BITS-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [`IJHD_DAT_BITS-1:0] wb_dat_i,
    output logic [`IJHD_DAT_BITS-1:0] wb_dat_o,
    output logic wb_ack_o,
    // power and row outputs
    output logic [`IJHD_NOZZLES-1:0] column_power_outputs_o,
    output logic [`IJHD_NOZZLES-1:0] test_current_sources_o,
    output logic [`IJHD_ROWS-1:0] row_outputs_head_a_o,
    output logic [`IJHD_ROWS-1:0] row_outputs_head_b_o,
    // temperature source, fault and converter data
    output logic temp_source_head_a_o,
    output logic temp_source_head_b_o,
    output logic fault_flag_out_o,
    output logic converter_serial_out_o
);

    // ****************************************************************
    // lookup functions
    // ****************************************************************

    // counter step to gray-style decoder code
    function automatic logic [3:0] ijhd_step_code(input logic [3:0] s);
        logic [3:0] c;
        c = 4'h0;
        case (s)
            4'h1: c = 4'h1;
            4'h2: c = 4'h3;
            4'h3: c = 4'h2;
            4'h4: c = 4'h6;
            4'h5: c = 4'h7;
            4'h6: c = 4'h5;
            4'h7: c = 4'h4;
            4'h8: c = 4'hc;
            4'h9: c = 4'hd;
            4'ha: c = 4'hf;
            4'hb: c = 4'he;
            4'hc: c = 4'ha;
            4'hd: c = 4'h8;
            default: c = 4'h0;
        endcase
        return c;
    endfunction

    // decoder code to one-hot row, bit 0 is row 1
    function automatic logic [12:0] ijhd_decode(input logic [3:0] c);
        logic [12:0] r;
        r = 13'h0000;
        case (c)
            4'h1: r = 13'h0001;
            4'h3: r = 13'h0002;
            4'h2: r = 13'h0004;
            4'h6: r = 13'h0008;
            4'h7: r = 13'h0010;
            4'h5: r = 13'h0020;
            4'h4: r = 13'h0040;
            4'hc: r = 13'h0080;
            4'hd: r = 13'h0100;
            4'hf: r = 13'h0200;
            4'he: r = 13'h0400;
            4'ha: r = 13'h0800;
            4'h8: r = 13'h1000;
            default: r = 13'h0000;
        endcase
        return r;
    endfunction

    // ****************************************************************
    // state and pin capture
    // ****************************************************************
    ijhd_pkg::ijhd_state_type q;
    ijhd_pkg::ijhd_state_type d;
    ijhd_pkg::ijhd_pins_type pins;
    ijhd_pkg::ijhd_pins_type rise;
    logic wb_req;

    // pins into one word, in struct order
    assign pins = {
        ctrl_word_latch_strobe_i,
        ctrl_serial_clock_i,
        ctrl_serial_in_i,
        nozzle_latch_clear_i,
        nozzle_check_mode_i,
        nozzle_latch_strobe_i,
        nozzle_serial_in_i,
        nozzle_serial_clock_i,
        long_fire_strobe_i,
        short_fire_strobe_i,
        conversion_start_i,
        converter_clock_i,
        scan_counter_enable_i,
        head_channel_select_i,
        row_code_bit3_i,
        count_direction_or_code_bit2_i,
        count_reset_or_code_bit1_i,
        count_clock_or_code_bit0_i,
        row_outputs_enable_n_i,
        temp_source_enable_n_i,
        open_load_detect_i,
        row_short_detect_i
    };

    // idle levels of the pulled-up pins, so no false edge after reset
    localparam ijhd_pkg::ijhd_pins_type pins_idle = '{
        long_fire_strobe: 1'b1,
        short_fire_strobe: 1'b1,
        row_outputs_enable_n: 1'b1,
        temp_source_enable_n: 1'b1,
        default: 1'b0
    };

    // rising edges from the second sync stage
    assign rise = ijhd_pkg::ijhd_pins_type'(q.sy2 & ~q.prev);
    assign wb_req = wb_cyc_i & wb_stb_i & ~q.ack;

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    always_comb begin
        logic [3:0] code;
        logic [12:0] onehot;
        code = 4'h0;
        onehot = 13'h0000;
        d = q;
        d.sy1 = pins;
        d.sy2 = q.sy1;
        d.prev = q.sy2;

        // nozzle shift register
        if (rise.nozzle_serial_clock) begin
            d.nshift = {q.nshift[`IJHD_NOZZLES-2:0],
                        q.sy2.nozzle_serial_in};
        end
        // nozzle latch, clear wins over load
        if (q.sy2.nozzle_latch_clear) begin
            d.nlatch = '0;
        end else if (rise.nozzle_latch_strobe) begin
            d.nlatch = q.nshift;
        end

        // column gating and nozzle check sources
        for (int i = 0; i < `IJHD_NOZZLES; i++) begin
            d.col[i] = ~q.sy2.nozzle_check_mode &
                ((~q.sy2.long_fire_strobe & q.nlatch[i]) |
                 (~q.sy2.short_fire_strobe & ~q.nlatch[i]));
            d.tsrc[i] = q.sy2.nozzle_check_mode & q.nlatch[i] &
                ~q.sy2.long_fire_strobe;
        end

        // control word serial port
        if (rise.ctrl_serial_clock) begin
            d.cshift = {q.cshift[`IJHD_CW_BITS-2:0],
                        q.sy2.ctrl_serial_in};
        end
        // transparent while strobe high, held from its fall
        if (q.sy2.ctrl_word_latch_strobe) begin
            d.cword = q.cshift;
        end

        // temperature current source
        d.temp_a = ~q.sy2.temp_source_enable_n &
            q.cword[`IJHD_CW_ON_BIT] &
            ~q.cword[`IJHD_CW_HEADB_BIT];
        d.temp_b = ~q.sy2.temp_source_enable_n &
            q.cword[`IJHD_CW_ON_BIT] &
            q.cword[`IJHD_CW_HEADB_BIT];

        // fault flag source by mode
        d.fault = q.sy2.nozzle_check_mode ? q.sy2.open_load_detect
                                          : q.sy2.row_short_detect;

        // scanning counter
        if (q.sy2.scan_counter_enable) begin
            if (!q.sy2.count_reset_or_code_bit1) begin
                d.step = `IJHD_STEP_ZERO;
            end else if (rise.count_clock_or_code_bit0) begin
                if (q.sy2.count_direction_or_code_bit2) begin
                    d.step = (q.step == `IJHD_STEP_LAST) ?
                        `IJHD_STEP_ZERO : q.step + `IJHD_STEP_ONE;
                end else begin
                    d.step = (q.step == `IJHD_STEP_ZERO) ?
                        `IJHD_STEP_LAST : q.step - `IJHD_STEP_ONE;
                end
            end
        end

        // decoder source and channel routing
        if (q.sy2.scan_counter_enable) begin
            code = ijhd_step_code(q.step);
        end else begin
            code = {q.sy2.row_code_bit3,
                    q.sy2.count_direction_or_code_bit2,
                    q.sy2.count_reset_or_code_bit1,
                    q.sy2.count_clock_or_code_bit0};
        end
        onehot = ijhd_decode(code);
        d.rows_a = '0;
        d.rows_b = '0;
        if (!q.sy2.row_outputs_enable_n) begin
            if (q.sy2.head_channel_select) begin
                d.rows_b = onehot;
            end else begin
                d.rows_a = onehot;
            end
        end

        // result shift-out on converter clock rise
        if (!q.sy2.conversion_start) begin
            d.adc_sh = q.result;
            d.adc_out = 1'b0;
        end else if (rise.converter_clock) begin
            d.adc_out = q.adc_sh[`IJHD_ADC_BITS-1];
            d.adc_sh = {q.adc_sh[`IJHD_ADC_BITS-2:0], 1'b0};
        end

        // wishbone slave, one wait state
        d.ack = wb_req;
        d.rdata = '0;
        if (wb_req && wb_we_i && wb_sel_i[0] &&
            wb_adr_i == `IJHD_ADR_RESULT) begin
            d.result = wb_dat_i[`IJHD_ADC_BITS-1:0];
        end
        if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                `IJHD_ADR_RESULT: begin
                    d.rdata = {24'h000000, q.result};
                end
                `IJHD_ADR_STATUS: begin
                    d.rdata = {11'h000, q.fault, q.step, 6'h00, q.cword};
                end
                `IJHD_ADR_LATCH: begin
                    d.rdata = {q.nshift, q.nlatch};
                end
                default: begin
                    d.rdata = '0;
                end
            endcase
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q <= '0;
            q.sy1 <= pins_idle;
            q.sy2 <= pins_idle;
            q.prev <= pins_idle;
            q.result <= `IJHD_RESULT_RST;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state flops
    assign column_power_outputs_o = q.col;
    assign test_current_sources_o = q.tsrc;
    assign row_outputs_head_a_o = q.rows_a;
    assign row_outputs_head_b_o = q.rows_b;
    assign temp_source_head_a_o = q.temp_a;
    assign temp_source_head_b_o = q.temp_b;
    assign fault_flag_out_o = q.fault;
    assign converter_serial_out_o = q.adc_out;
    assign wb_dat_o = q.rdata;
    assign wb_ack_o = q.ack;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    chk_check_cols_off: assert property (
        q.sy2.nozzle_check_mode |=> column_power_outputs_o == '0)
        else $error("columns on during nozzle check");
    chk_latch_clear: assert property (
        q.sy2.nozzle_latch_clear |=> q.nlatch == '0)
        else $error("latch not cleared");
    chk_latch_load: assert property (
        rise.nozzle_latch_strobe && !q.sy2.nozzle_latch_clear
        |=> q.nlatch == $past(q.nshift))
        else $error("latch did not copy shift register");
    chk_nozzle_shift: assert property (
        rise.nozzle_serial_clock |=> q.nshift[0] ==
        $past(q.sy2.nozzle_serial_in) && q.nshift[15:1] ==
        $past(q.nshift[14:0]))
        else $error("nozzle shift wrong");
    chk_long_fire: assert property (
        !q.sy2.nozzle_check_mode && !q.sy2.long_fire_strobe
        |=> (column_power_outputs_o & $past(q.nlatch)) == $past(q.nlatch))
        else $error("long strobe missed a set column");
    chk_short_fire: assert property (
        !q.sy2.nozzle_check_mode && !q.sy2.short_fire_strobe
        |=> (column_power_outputs_o | $past(q.nlatch)) == '1)
        else $error("short strobe missed a clear column");
    chk_cword_hold: assert property (
        !q.sy2.ctrl_word_latch_strobe |=> $stable(q.cword))
        else $error("control word changed with strobe low");
    chk_cnt_reset: assert property (
        q.sy2.scan_counter_enable && !q.sy2.count_reset_or_code_bit1
        |=> q.step == `IJHD_STEP_ZERO)
        else $error("counter not reset");
    chk_step_range: assert property (
        q.step <= `IJHD_STEP_LAST)
        else $error("counter outside its 14 steps");
    chk_rows_off: assert property (
        q.sy2.row_outputs_enable_n |=> row_outputs_head_a_o == '0 &&
        row_outputs_head_b_o == '0)
        else $error("rows driven while disabled");
    chk_one_channel: assert property (
        !(row_outputs_head_a_o != '0 && row_outputs_head_b_o != '0))
        else $error("both head channels driven");
    chk_wb_ack: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("wishbone ack not a single cycle");

    cov_counter_wrap: cover property (
        q.step == `IJHD_STEP_LAST ##[1:300] q.step == `IJHD_STEP_ZERO);
    cov_nozzle_fire: cover property (column_power_outputs_o != '0);
    cov_adc_shift: cover property (
        q.sy2.conversion_start && rise.converter_clock);
    cov_row_b: cover property (row_outputs_head_b_o != '0);

endmodule

// file: ijhd_ctrl_model.sv
`timescale 1ns/1ns
// ****************************************************************
// printer controller model
// ****************************************************************
module ijhd_ctrl_model (
    // clock
    input wire logic ref_clk_i,
    // converter data from the driver
    input wire logic converter_serial_out_i,
    // nozzle port
    output logic nozzle_serial_clock_o,
    output logic nozzle_serial_in_o,
    output logic nozzle_latch_strobe_o,
    // control word port
    output logic ctrl_serial_clock_o,
    output logic ctrl_serial_in_o,
    output logic ctrl_word_latch_strobe_o,
    // converter port
    output logic conversion_start_o,
    output logic converter_clock_o
);
    logic [1:0] sclk, sdat, lstb;
    // bit 1 drives the control word port, bit 0 the nozzle port
    assign {ctrl_serial_clock_o, nozzle_serial_clock_o} = sclk;
    assign {ctrl_serial_in_o, nozzle_serial_in_o} = sdat;
    assign {ctrl_word_latch_strobe_o, nozzle_latch_strobe_o} = lstb;
    // idle levels; clocks stand still between frames
    initial begin
        {sclk, sdat, lstb} = 6'h00;
        {conversion_start_o, converter_clock_o} = 2'h0;
    end
    // wait whole clocks; the driver needs pins stable for 3
    task automatic hold(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    // shift n bits msb first on the chosen port
    task automatic send(input logic ctl, input int n, input logic [15:0] w);
        for (int i = n - 1; i >= 0; i--) begin
            sdat[ctl] <= w[i];
            hold(4);
            sclk[ctl] <= 1'h1;
            hold(4);
            sclk[ctl] <= 1'h0;
        end
        // data no longer valid once the frame ends
        sdat[ctl] <= ~w[0];
        hold(4);
    endtask
    // latch pulse, only after a whole word; fire strobes stay idle
    task automatic latch(input logic ctl);
        lstb[ctl] <= 1'h1;
        hold(4);
        lstb[ctl] <= 1'h0;
        hold(4);
    endtask
    // settle, then eight bits read at clock fall
    task automatic read(output logic [7:0] v);
        hold(80);
        conversion_start_o <= 1'h1;
        hold(4);
        for (int i = 7; i >= 0; i--) begin
            converter_clock_o <= 1'h1;
            hold(3);
            @(negedge ref_clk_i);
            v[i] = converter_serial_out_i;
            hold(1);
            converter_clock_o <= 1'h0;
            hold(4);
        end
        conversion_start_o <= 1'h0;
        hold(4);
    endtask
endmodule

// file: ijhd_top_bench.sv
`timescale 1ns/1ns
// ****************************************************************
// self-checking bench for the head driver logic
// ****************************************************************
module ijhd_top_bench;
    logic ref_clk_i, arst_n_i, nozzle_latch_clear_i, nozzle_check_mode_i;
    logic long_fire_strobe_i, short_fire_strobe_i, scan_counter_enable_i;
    logic head_channel_select_i, row_code_bit3_i, row_outputs_enable_n_i;
    logic count_direction_or_code_bit2_i, count_reset_or_code_bit1_i;
    logic count_clock_or_code_bit0_i, temp_source_enable_n_i;
    logic open_load_detect_i, row_short_detect_i, wb_cyc_i, wb_stb_i;
    logic wb_we_i, wb_ack_o, converter_serial_out_o, fault_flag_out_o;
    logic temp_source_head_a_o, temp_source_head_b_o;
    logic [7:0] wb_adr_i, v;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [15:0] column_power_outputs_o, test_current_sources_o, e16, lat;
    logic [12:0] row_outputs_head_a_o, row_outputs_head_b_o, e;
    wire ctrl_word_latch_strobe_i, ctrl_serial_clock_i, ctrl_serial_in_i;
    wire nozzle_latch_strobe_i, nozzle_serial_in_i, nozzle_serial_clock_i;
    wire conversion_start_i, converter_clock_i;
    int bad_count, check_count, s;
    // decoder rows: enable_n, select, code, expected row (0 = none)
    logic [15:0] rows [18] = '{16'h0000, 16'h0011, 16'h0132, 16'h0023,
        16'h0164, 16'h0075, 16'h0156, 16'h0047, 16'h01c8, 16'h00d9,
        16'h01fa, 16'h00eb, 16'h01ac, 16'h008d, 16'h0190, 16'h00b0,
        16'h1130, 16'h1010};

    ijhd_top u_dut (
        .ref_clk_i, .arst_n_i, .ctrl_word_latch_strobe_i, .ctrl_serial_clock_i,
        .ctrl_serial_in_i, .nozzle_latch_clear_i, .nozzle_check_mode_i,
        .nozzle_latch_strobe_i, .nozzle_serial_in_i, .nozzle_serial_clock_i,
        .long_fire_strobe_i, .short_fire_strobe_i, .conversion_start_i,
        .converter_clock_i, .scan_counter_enable_i, .head_channel_select_i,
        .row_code_bit3_i, .count_direction_or_code_bit2_i,
        .count_reset_or_code_bit1_i, .count_clock_or_code_bit0_i,
        .row_outputs_enable_n_i, .temp_source_enable_n_i, .open_load_detect_i,
        .row_short_detect_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .column_power_outputs_o,
        .test_current_sources_o, .row_outputs_head_a_o, .row_outputs_head_b_o,
        .temp_source_head_a_o, .temp_source_head_b_o, .fault_flag_out_o,
        .converter_serial_out_o);
    ijhd_ctrl_model u_ctrl (
        .ref_clk_i, .converter_serial_out_i(converter_serial_out_o),
        .nozzle_serial_clock_o(nozzle_serial_clock_i),
        .nozzle_serial_in_o(nozzle_serial_in_i),
        .nozzle_latch_strobe_o(nozzle_latch_strobe_i),
        .ctrl_serial_clock_o(ctrl_serial_clock_i),
        .ctrl_serial_in_o(ctrl_serial_in_i),
        .ctrl_word_latch_strobe_o(ctrl_word_latch_strobe_i),
        .conversion_start_o(conversion_start_i),
        .converter_clock_o(converter_clock_i));

    // 10 MHz clock
    initial begin
        ref_clk_i = 1'h0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // classic wishbone cycle; read data taken at the ack edge
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] sl);
        int n;
        n = 0;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
        {wb_adr_i, wb_dat_i, wb_sel_i} <= {a, d, sl};
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 64);
        q = wb_dat_o;
        if (n == 64) begin
            bad_count++;
            report_and_stop();
        end
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a);
        wb(1'h0, a, 32'h0, 4'hf);
    endtask

    // main sequence
    initial begin
        {arst_n_i, nozzle_latch_clear_i, nozzle_check_mode_i} = 3'h0;
        {long_fire_strobe_i, short_fire_strobe_i} = 2'h3;
        {scan_counter_enable_i, head_channel_select_i, row_code_bit3_i} = 3'h0;
        {count_direction_or_code_bit2_i, count_reset_or_code_bit1_i} = 2'h0;
        count_clock_or_code_bit0_i = 1'h0;
        {row_outputs_enable_n_i, temp_source_enable_n_i} = 2'h3;
        {open_load_detect_i, row_short_detect_i, wb_cyc_i, wb_stb_i} = 4'h0;
        {wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {bad_count, check_count, lat} = {32'h0, 32'h0, 16'hc3a5};
        tick(3);
        chk({column_power_outputs_o, test_current_sources_o}, 32'h0);
        arst_n_i <= 1'h1;
        tick(1);
        for (int i = 0; i < 4; i++) begin
            rd(8'(4 * i));
            chk(q, 32'h0);
        end
        $display("test reset done");
        foreach (rows[i]) begin
            row_outputs_enable_n_i <= rows[i][12];
            head_channel_select_i <= rows[i][8];
            {row_code_bit3_i, count_direction_or_code_bit2_i,
             count_reset_or_code_bit1_i, count_clock_or_code_bit0_i}
                <= rows[i][7:4];
            tick(5);
            e = rows[i][3:0] == 4'h0 ? 13'h0 : 13'h1 << (rows[i][3:0] - 4'h1);
            chk({row_outputs_head_a_o, row_outputs_head_b_o},
                rows[i][8] ? {13'h0, e} : {e, 13'h0});
        end
        $display("test decoder done");
        u_ctrl.send(1'h0, 16, lat);
        rd(8'h08);
        chk(q, {lat, 16'h0});
        u_ctrl.latch(1'h0);
        rd(8'h08);
        chk(q, {lat, lat});
        for (int j = 0; j < 8; j++) begin
            {nozzle_check_mode_i, long_fire_strobe_i, short_fire_strobe_i}
                <= j[2:0];
            tick(5);
            e16 = j[2] ? 16'h0 : (j[1] ? 16'h0 : lat) | (j[0] ? 16'h0 : ~lat);
            chk({column_power_outputs_o, test_current_sources_o},
                {e16, (j[2] & ~j[1]) ? lat : 16'h0});
        end
        for (int k = 0; k < 8; k++) begin
            {nozzle_check_mode_i, open_load_detect_i, row_short_detect_i}
                <= k[2:0];
            tick(5);
            chk({31'h0, fault_flag_out_o}, {31'h0, k[2] ? k[1] : k[0]});
        end
        nozzle_latch_clear_i <= 1'h1;
        u_ctrl.latch(1'h0);
        rd(8'h08);
        chk(q, {lat, 16'h0});
        nozzle_latch_clear_i <= 1'h0;
        long_fire_strobe_i <= 1'h0;
        tick(5);
        chk({16'h0, column_power_outputs_o}, 32'h0);
        long_fire_strobe_i <= 1'h1;
        $display("test nozzle done");
        u_ctrl.send(1'h1, 10, 16'h0203);
        rd(8'h04);
        chk(q & 32'h3ff, 32'h0);
        u_ctrl.latch(1'h1);
        rd(8'h04);
        chk(q & 32'h3ff, 32'h203);
        temp_source_enable_n_i <= 1'h0;
        tick(5);
        chk({temp_source_head_a_o, temp_source_head_b_o}, 32'h1);
        u_ctrl.send(1'h1, 10, 16'h0101);
        u_ctrl.latch(1'h1);
        chk({temp_source_head_a_o, temp_source_head_b_o}, 32'h2);
        temp_source_enable_n_i <= 1'h1;
        tick(5);
        chk({temp_source_head_a_o, temp_source_head_b_o}, 32'h0);
        $display("test control done");
        {scan_counter_enable_i, head_channel_select_i} <= 2'h2;
        {row_outputs_enable_n_i, count_clock_or_code_bit0_i} <= 2'h0;
        {count_direction_or_code_bit2_i, count_reset_or_code_bit1_i} <= 2'h2;
        tick(5);
        count_reset_or_code_bit1_i <= 1'h1;
        for (int k = 1; k <= 16; k++) begin
            count_direction_or_code_bit2_i <= k <= 14;
            tick(4);
            count_clock_or_code_bit0_i <= 1'h1;
            tick(4);
            count_clock_or_code_bit0_i <= 1'h0;
            tick(5);
            s = k <= 14 ? k % 14 : 28 - k;
            e = s == 0 ? 13'h0 : 13'h1 << (s - 1);
            rd(8'h04);
            chk({q[19:16], row_outputs_head_a_o},
                {4'(s), e});
        end
        count_reset_or_code_bit1_i <= 1'h0;
        tick(5);
        rd(8'h04);
        chk({q[19:16], row_outputs_head_a_o}, 32'h0);
        $display("test counter done");
        wb(1'h1, 8'h00, 32'h96, 4'hf);
        wb(1'h1, 8'h00, 32'h5a, 4'he);
        rd(8'h00);
        chk(q, 32'h96);
        chk({31'h0, converter_serial_out_o}, 32'h0);
        u_ctrl.read(v);
        chk({24'h0, v}, 32'h96);
        $display("test converter done");
        arst_n_i <= 1'h0;
        tick(2);
        arst_n_i <= 1'h1;
        tick(1);
        rd(8'h08);
        chk(q, 32'h0);
        $display("test second reset done");
        report_and_stop();
    end
endmodule
